// >>> rtl/plsc_pkg.sv
// Constants for the link status and slot capability register block
package plsc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_LINK_CTL = 12'h050;
  localparam logic [11:0] IDX_LINK_STS = 12'h052;
  localparam logic [11:0] IDX_SLOT_CAP = 12'h054;
  localparam logic [11:0] IDX_PORT_CFG = 12'h056;
  localparam logic [11:0] ADDR_LINK_CTL = {IDX_LINK_CTL[9:0], 2'b00};
  localparam logic [11:0] ADDR_LINK_STS = {IDX_LINK_STS[9:0], 2'b00};
  localparam logic [11:0] ADDR_SLOT_CAP = {IDX_SLOT_CAP[9:0], 2'b00};
  localparam logic [11:0] ADDR_PORT_CFG = {IDX_PORT_CFG[9:0], 2'b00};
  // Link control bit positions
  localparam int CTL_RETRAIN = 5;
  localparam int CTL_WIDTH_INHIBIT = 9;
  localparam int CTL_BW_MGMT_IE = 10;
  localparam int CTL_AUTO_BW_IE = 11;
  // Link status field positions
  localparam int STS_SPEED_LSB = 0;
  localparam int STS_WIDTH_LSB = 4;
  localparam int STS_TRAIN_ERR = 10;
  localparam int STS_TRAINING = 11;
  localparam int STS_SLOT_CLK = 12;
  localparam int STS_DL_ACTIVE = 13;
  localparam int STS_BW_MGMT = 14;
  localparam int STS_AUTO_BW = 15;
  // Port configuration bit positions
  localparam int CFG_LEGACY = 0;
  localparam int CFG_BW_NOTIFY = 1;
  localparam int CFG_SLOT_IMPL = 2;
  localparam int CFG_DL_REPORT = 3;
  localparam int CFG_LOCK = 4;
  localparam int CFG_REV_1_0A = 5;
  localparam int CFG_BITS = 6;
  localparam int SLOT_BITS = 6;
  // Reset values and codes
  localparam logic [3:0] SPEED_GEN1 = 4'h1;
  localparam logic [3:0] SPEED_GEN2 = 4'h2;
  localparam logic [3:0] SPEED_RST = 4'h1;
  localparam logic [5:0] WIDTH_RST = 6'h04;
  localparam logic [CFG_BITS-1:0] CFG_RST = 6'h00;
  localparam logic [SLOT_BITS-1:0] SLOT_RST = 6'h00;
  localparam logic [2:0] TS_RUN_LAST = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : plsc_pkg

// >>> rtl/plsc_regs.sv
// Link control, link status and slot capability registers of one switch port
//
// Notes on behaviour
// - Width-change inhibit stops own width changes except reliability reductions.
// - Legacy mode: inhibit, both enables and both flags read zero, ignore writes.
// - Autonomous-bandwidth enable raises interrupt when its flag becomes set.
// - Without bandwidth-notify capability, both enables and both flags are zero.
// - Speed field resets to 1; reports 1 for 2.5 Gbps, 2 for 5 Gbps.
// - Width field reports negotiated lane width; reset value set by hardware.
// - Training bit high while link training runs; resets to zero.
// - Slot clock bit starts from port's common-clock strap; software may override until locked.
// - Data-link active bit follows active state; zero without reporting capability.
// - Bandwidth-management flag set on retrain completion without DL_Down; W1C.
// - Bandwidth-management flag also set on reliability-driven speed/width change.
// - Autonomous flag set on other autonomous speed/width change; write-one-to-clear.
// - Slot bits 0..4 report fitted button, power, latch, indicators; reset zero.
// - Slot bit 5 reports surprise removal possible.
// - Slot bits read zero without slot implemented; otherwise writable until locked.
// - Writing one to retrain request sends training machine to Recovery.
`timescale 1ns/1ps
module plsc_regs #(
  parameter logic [5:0] RESET_WIDTH = plsc_pkg::WIDTH_RST
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic upstream_port,
  input wire logic up_common_clock_strap,
  input wire logic down_common_clock_strap,
  input wire logic [3:0] phy_speed,
  input wire logic [5:0] phy_width,
  input wire logic phy_training,
  input wire logic phy_train_error,
  input wire logic phy_retrain_done,
  input wire logic phy_fix_change,
  input wire logic phy_other_change,
  input wire logic ts_valid,
  input wire logic ts_autonomous,
  input wire logic dl_up,
  input wire logic dl_down,
  output logic retrain_request,
  output logic width_change_inhibit,
  output logic bw_irq
);
  import plsc_pkg::*;

  // Bus slave state
  logic aw_held_r, w_held_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  // Register state
  logic [CFG_BITS-1:0] cfg_r;
  logic [SLOT_BITS-1:0] slot_r;
  logic inhibit_raw_r, bwm_ie_raw_r, abw_ie_raw_r;
  logic bwm_r, abw_r, bwm_nxt, abw_nxt;
  logic [3:0] speed_r;
  logic [5:0] width_r;
  logic train_err_r, training_r, dl_active_r, sclk_r, strap_done_r;
  logic retrain_pend_r, retrain_r, inhibit_r, irq_r;
  logic [2:0] ts_cnt_r, ts_cnt_nxt;

  // Decoding
  wire aw_take = s_axi_awvalid & awready_r;
  wire w_take = s_axi_wvalid & wready_r;
  wire wr_fire = aw_held_r & w_held_r & ~bvalid_r;
  wire ar_take = s_axi_arvalid & arready_r;
  wire wsel_ctl = wr_fire & (awaddr_r == ADDR_LINK_CTL);
  wire wsel_sts = wr_fire & (awaddr_r == ADDR_LINK_STS);
  wire wsel_slot = wr_fire & (awaddr_r == ADDR_SLOT_CAP);
  wire wsel_cfg = wr_fire & (awaddr_r == ADDR_PORT_CFG);
  wire wr_hit = wsel_ctl | wsel_sts | wsel_slot | wsel_cfg;
  wire wr_lo = wstrb_r[0];
  wire wr_hi = wstrb_r[1];
  wire legacy = cfg_r[CFG_LEGACY];
  wire bw_allowed = cfg_r[CFG_BW_NOTIFY] & ~legacy;
  wire locked = cfg_r[CFG_LOCK];
  wire slot_impl = cfg_r[CFG_SLOT_IMPL];

  // Effective control bits
  wire inhibit_eff = inhibit_raw_r & ~legacy;
  wire bwm_ie_eff = bwm_ie_raw_r & bw_allowed;
  wire abw_ie_eff = abw_ie_raw_r & bw_allowed;
  wire retrain_wr = wsel_ctl & wr_lo & wdata_r[CTL_RETRAIN];

  // Flag events
  wire ts_hit = ts_valid & ts_autonomous & ~upstream_port & (ts_cnt_r == TS_RUN_LAST);
  wire bwm_set = bw_allowed & ~dl_down &
                 ((phy_retrain_done & retrain_pend_r) | phy_fix_change);
  wire abw_set = bw_allowed & (phy_other_change | ts_hit);
  wire bwm_clr = wsel_sts & wr_hi & wdata_r[STS_BW_MGMT];
  wire abw_clr = wsel_sts & wr_hi & wdata_r[STS_AUTO_BW];
  wire irq_evt = (bwm_ie_eff & bwm_set & ~bwm_r) | (abw_ie_eff & abw_set & ~abw_r);
  wire speed_ok = (phy_speed == SPEED_GEN1) | (phy_speed == SPEED_GEN2);

  // Read views
  wire [SLOT_BITS-1:0] slot_view = slot_impl ? slot_r : '0;
  wire [15:0] ctl_view = {4'h0, abw_ie_eff, bwm_ie_eff, inhibit_eff, 9'h000};
  wire [15:0] sts_view = {abw_r & bw_allowed, bwm_r & bw_allowed, dl_active_r, sclk_r,
                          training_r, train_err_r, width_r, speed_r};
  wire sel_ctl_rd = araddr_is(ADDR_LINK_CTL);
  wire sel_sts_rd = araddr_is(ADDR_LINK_STS);
  wire sel_slot_rd = araddr_is(ADDR_SLOT_CAP);
  wire sel_cfg_rd = araddr_is(ADDR_PORT_CFG);
  wire rd_hit = sel_ctl_rd | sel_sts_rd | sel_slot_rd | sel_cfg_rd;
  wire [31:0] rd_word = sel_ctl_rd ? {16'h0000, ctl_view} :
                        sel_sts_rd ? {16'h0000, sts_view} :
                        sel_slot_rd ? {26'h0, slot_view} :
                        sel_cfg_rd ? {26'h0, cfg_r} : 32'h0000_0000;

  function automatic logic araddr_is(input logic [11:0] a);
    araddr_is = (s_axi_araddr == a);
  endfunction : araddr_is

  assign bwm_nxt = bw_allowed & (bwm_set | (bwm_r & ~bwm_clr));
  assign abw_nxt = bw_allowed & (abw_set | (abw_r & ~abw_clr));

  always_comb begin
    ts_cnt_nxt = ts_cnt_r;
    if (ts_valid) begin
      ts_cnt_nxt = (ts_autonomous && ts_cnt_r != TS_RUN_LAST) ? 3'(ts_cnt_r + 3'h1) : 3'h0;
    end
  end

  // Write address and data channels, taken in either order
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (ce) begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
      if (bvalid_r && s_axi_bready) begin
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Write response and read channel
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (ar_take) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        arready_r <= 1'b1;
        rvalid_r <= 1'b0;
      end
    end
  end

  // Software-written control and configuration
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_r <= CFG_RST;
      slot_r <= SLOT_RST;
      inhibit_raw_r <= 1'b0;
      bwm_ie_raw_r <= 1'b0;
      abw_ie_raw_r <= 1'b0;
    end else if (ce) begin
      if (wsel_cfg && wr_lo) begin
        cfg_r <= wdata_r[CFG_BITS-1:0];
      end
      if (wsel_slot && wr_lo && slot_impl && !locked) begin
        slot_r <= wdata_r[SLOT_BITS-1:0];
      end
      if (wsel_ctl && wr_hi && !legacy) begin
        inhibit_raw_r <= wdata_r[CTL_WIDTH_INHIBIT];
        bwm_ie_raw_r <= wdata_r[CTL_BW_MGMT_IE] & bw_allowed;
        abw_ie_raw_r <= wdata_r[CTL_AUTO_BW_IE] & bw_allowed;
      end
    end
  end

  // Link status tracking
  always_ff @(posedge clk) begin
    if (!resetn) begin
      speed_r <= SPEED_RST;
      width_r <= RESET_WIDTH;
      train_err_r <= 1'b0;
      training_r <= 1'b0;
      dl_active_r <= 1'b0;
    end else if (ce) begin
      if (speed_ok) begin
        speed_r <= phy_speed;
      end
      if (!phy_training) begin
        width_r <= phy_width;
      end
      if (!cfg_r[CFG_REV_1_0A] || retrain_wr) begin
        train_err_r <= 1'b0;
      end else if (phy_train_error) begin
        train_err_r <= 1'b1;
      end
      training_r <= phy_training;
      dl_active_r <= dl_up & cfg_r[CFG_DL_REPORT];
    end
  end

  // Slot clock bit: strap caught once after reset release, then writable until locked
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclk_r <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (ce) begin
      if (!strap_done_r) begin
        sclk_r <= upstream_port ? up_common_clock_strap : down_common_clock_strap;
        strap_done_r <= 1'b1;
      end else if (wsel_sts && wr_hi && !locked) begin
        sclk_r <= wdata_r[STS_SLOT_CLK];
      end
    end
  end

  // Bandwidth flags, retrain tracking and outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bwm_r <= 1'b0;
      abw_r <= 1'b0;
      ts_cnt_r <= 3'h0;
      retrain_pend_r <= 1'b0;
      retrain_r <= 1'b0;
      inhibit_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce) begin
      bwm_r <= bwm_nxt;
      abw_r <= abw_nxt;
      ts_cnt_r <= ts_cnt_nxt;
      if (retrain_wr) begin
        retrain_pend_r <= 1'b1;
      end else if (phy_retrain_done || dl_down) begin
        retrain_pend_r <= 1'b0;
      end
      retrain_r <= retrain_wr;
      inhibit_r <= inhibit_eff;
      irq_r <= irq_evt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign retrain_request = retrain_r;
  assign width_change_inhibit = inhibit_r;
  assign bw_irq = irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  retrain_pulse_a: assert property (ce && retrain_wr |=> retrain_request)
    else $error("retrain write did not pulse retrain request");
  bwm_flag_set_a: assert property (ce && bwm_set |=> bwm_r)
    else $error("bandwidth management flag not set");
  abw_flag_set_a: assert property (ce && abw_set |=> abw_r)
    else $error("autonomous bandwidth flag not set");
  legacy_zero_a: assert property (ce && legacy |=> sts_view[15:14] == 2'b00 && !inhibit_r)
    else $error("legacy mode bits not zero");
  nocap_zero_a: assert property (!cfg_r[CFG_BW_NOTIFY] |-> ctl_view[11:10] == 2'b00)
    else $error("interrupt enables not zero without capability");
  mgmt_irq_a: assert property (ce && bwm_ie_eff && bwm_set && !bwm_r |=> bw_irq && bwm_r)
    else $error("missing bandwidth management interrupt");
  auto_irq_a: assert property (ce && abw_ie_eff && abw_set && !abw_r |=> bw_irq)
    else $error("missing autonomous bandwidth interrupt");
  training_track_a: assert property (ce && resetn |=> training_r == $past(phy_training))
    else $error("training bit does not follow training");
  dl_active_a: assert property (ce && resetn |=>
    dl_active_r == ($past(dl_up) && $past(cfg_r[CFG_DL_REPORT])))
    else $error("data link active bit wrong");
  slot_zero_a: assert property (!slot_impl |-> slot_view == '0)
    else $error("slot bits visible without slot");
  flag_hold_a: assert property (ce && bwm_r && bw_allowed && !bwm_clr |=> bwm_r)
    else $error("flag lost without a clear");
  speed_code_a: assert property (speed_r == SPEED_GEN1 || speed_r == SPEED_GEN2)
    else $error("illegal speed code");
  ts_run_a: assert property (ce && ts_hit && bw_allowed |=> abw_r)
    else $error("eight autonomous sets did not set flag");
  inhibit_out_a: assert property (ce && resetn |=>
    width_change_inhibit == $past(inhibit_eff))
    else $error("inhibit output mismatch");

  write_done_c: cover property (wr_fire && wsel_sts ##[1:4] s_axi_bvalid && s_axi_bready);
  read_done_c: cover property (ar_take ##1 rvalid_r && s_axi_rready);
  retrain_flag_c: cover property (retrain_wr ##[1:50] bwm_r);
  ts_flag_c: cover property (ts_hit ##1 abw_r);
endmodule : plsc_regs

// >>> sim/plsc_link_partner.sv
// Link partner and link-layer model driving the port's status inputs
`timescale 1ns/1ps
module plsc_link_partner #(
  parameter int TRAIN_CYC = 20
) (
  input wire logic clk,
  input wire logic retrain_request,
  output logic [3:0] phy_speed,
  output logic [5:0] phy_width,
  output logic phy_training,
  output logic phy_train_error,
  output logic phy_retrain_done,
  output logic phy_fix_change,
  output logic phy_other_change,
  output logic ts_valid,
  output logic ts_autonomous,
  output logic dl_up,
  output logic dl_down
);
  int cnt_r = 0;
  initial begin
    phy_speed = 4'h1;
    phy_width = 6'h01;
    phy_training = 1'h1;
    {phy_train_error, phy_retrain_done, phy_fix_change, phy_other_change} = 4'h0;
    {ts_valid, ts_autonomous, dl_up, dl_down} = 4'h0;
  end
  // Retrain: train for a while, then report completion without DL_Down
  always @(posedge clk) begin
    phy_retrain_done <= (cnt_r == 1);
    if (retrain_request) begin
      cnt_r <= TRAIN_CYC;
      phy_training <= 1'h1;
    end else if (cnt_r > 0) begin
      cnt_r <= cnt_r - 1;
      phy_training <= (cnt_r > 1);
    end
  end
  task automatic link_up(input logic [3:0] s, input logic [5:0] w);
    @(posedge clk);
    phy_speed <= s;
    phy_width <= w;
    phy_training <= 1'h0;
    dl_up <= 1'h1;
  endtask : link_up
  task automatic send_ts(input int n, input logic auto_bit);
    repeat (n) begin
      @(posedge clk);
      ts_valid <= 1'h1;
      ts_autonomous <= auto_bit;
    end
    @(posedge clk);
    ts_valid <= 1'h0;
    ts_autonomous <= ~auto_bit;
  endtask : send_ts
  // Kind 0 reliability change, 1 other autonomous change, 2 training error
  task automatic pulse(input int k);
    @(posedge clk);
    {phy_fix_change, phy_other_change, phy_train_error} <= 3'h4 >> k;
    @(posedge clk);
    {phy_fix_change, phy_other_change, phy_train_error} <= 3'h0;
  endtask : pulse
endmodule : plsc_link_partner

// >>> sim/tb.sv
// Self-checking bench for the link status and slot capability registers
`timescale 1ns/1ps
module tb;
  import plsc_pkg::*;
  localparam logic [5:0] RW = 6'h02;
  logic clk, resetn, ce, upstream_port, up_common_clock_strap, down_common_clock_strap;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, phy_speed;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] phy_width;
  logic phy_training, phy_train_error, phy_retrain_done, phy_fix_change, phy_other_change;
  logic ts_valid, ts_autonomous, dl_up, dl_down, retrain_request, width_change_inhibit, bw_irq;
  int failures = 0, compares = 0, cycles = 0, irq_n = 0, rt_n = 0;

  plsc_regs #(.RESET_WIDTH(RW)) DUT (.clk, .resetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .upstream_port, .up_common_clock_strap,
    .down_common_clock_strap, .phy_speed, .phy_width, .phy_training, .phy_train_error,
    .phy_retrain_done, .phy_fix_change, .phy_other_change, .ts_valid, .ts_autonomous, .dl_up,
    .dl_down, .retrain_request, .width_change_inhibit, .bw_irq);
  plsc_link_partner lp (.clk, .retrain_request, .phy_speed, .phy_width, .phy_training,
    .phy_train_error, .phy_retrain_done, .phy_fix_change, .phy_other_change, .ts_valid,
    .ts_autonomous, .dl_up, .dl_down);

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    irq_n <= irq_n + bw_irq;
    rt_n <= rt_n + retrain_request;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw && w)) begin
      @(posedge clk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'h1);
    // Ready stays high, so a following call never lowers and raises it in one step
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    rsp = s_axi_rresp;
    chk(n, s_axi_rdata, e);
  endtask : rc
  // Flags: auto, mgmt, dl active, slot clock, training, training error
  function automatic logic [31:0] st(input logic [3:0] s, input logic [5:0] f);
    return {16'h0000, f, 6'h08, s};
  endfunction : st

  initial begin
    {resetn, upstream_port, up_common_clock_strap} = 3'h0;
    {ce, down_common_clock_strap} = 2'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    rc("sts_rst", ADDR_LINK_STS, {16'h0000, 6'h06, RW, SPEED_RST});
    rc("slot_rst", ADDR_SLOT_CAP, 32'h0);
    rc("ctl_rst", ADDR_LINK_CTL, 32'h0);
    lp.link_up(SPEED_GEN2, 6'h08);
    @(posedge clk);
    rc("dl_off", ADDR_LINK_STS, st(SPEED_GEN2, 6'h04));
    wr(ADDR_PORT_CFG, 32'h2E);
    rc("dl_on", ADDR_LINK_STS, st(SPEED_GEN2, 6'h0C));
    wr(ADDR_LINK_CTL, 32'hE00);
    rc("ctl_en", ADDR_LINK_CTL, 32'hE00);
    chk("inhibit", width_change_inhibit, 32'h1);
    wr(ADDR_LINK_CTL, 32'hE20);
    // Partner starts training one edge after the pulse, the bit follows one edge later
    repeat (2) @(posedge clk);
    rc("training", ADDR_LINK_STS, st(SPEED_GEN2, 6'h0E));
    wait (irq_n == 1);
    rc("retrained", ADDR_LINK_STS, st(SPEED_GEN2, 6'h1C));
    chk("retrain_n", rt_n, 32'h1);
    wr(ADDR_LINK_STS, 32'h1000);
    rc("zero_wr", ADDR_LINK_STS, st(SPEED_GEN2, 6'h1C));
    wr(ADDR_LINK_STS, 32'h5000);
    rc("w1c", ADDR_LINK_STS, st(SPEED_GEN2, 6'h0C));
    for (int k = 0; k < 2; k++) begin
      lp.pulse(k);
      wait (irq_n == 2 + k);
      rc("auto_chg", ADDR_LINK_STS, st(SPEED_GEN2, k ? 6'h2C : 6'h1C));
      wr(ADDR_LINK_STS, k ? 32'h9000 : 32'h5000);
    end
    lp.send_ts(7, 1'h1);
    lp.send_ts(1, 1'h0);
    lp.send_ts(7, 1'h1);
    rc("ts_restart", ADDR_LINK_STS, st(SPEED_GEN2, 6'h0C));
    lp.send_ts(1, 1'h1);
    wait (irq_n == 4);
    rc("ts_eight", ADDR_LINK_STS, st(SPEED_GEN2, 6'h2C));
    wr(ADDR_LINK_STS, 32'h9000);
    wr(ADDR_LINK_CTL, 32'h200);
    lp.pulse(1);
    rc("masked", ADDR_LINK_STS, st(SPEED_GEN2, 6'h2C));
    chk("irq_masked", irq_n, 32'h4);
    wr(ADDR_LINK_STS, 32'h9000);
    lp.link_up(4'h3, 6'h08);
    @(posedge clk);
    rc("speed_rsvd", ADDR_LINK_STS, st(SPEED_GEN2, 6'h0C));
    lp.pulse(2);
    rc("train_err", ADDR_LINK_STS, st(SPEED_GEN2, 6'h0D));
    // Clock enable low: an autonomous change must be ignored
    ce <= 1'h0;
    lp.pulse(1);
    ce <= 1'h1;
    rc("ce_freeze", ADDR_LINK_STS, st(SPEED_GEN2, 6'h0D));
    wr(ADDR_PORT_CFG, 32'h0F);
    wr(ADDR_LINK_CTL, 32'hE00);
    rc("ctl_legacy", ADDR_LINK_CTL, 32'h0);
    lp.pulse(0);
    rc("sts_legacy", ADDR_LINK_STS, st(SPEED_GEN2, 6'h0C));
    wr(ADDR_PORT_CFG, 32'h2C);
    wr(ADDR_LINK_CTL, 32'hE00);
    rc("ctl_nobw", ADDR_LINK_CTL, 32'h200);
    lp.pulse(1);
    rc("sts_nobw", ADDR_LINK_STS, st(SPEED_GEN2, 6'h0C));
    wr(ADDR_SLOT_CAP, 32'h3F);
    rc("slot_wr", ADDR_SLOT_CAP, 32'h3F);
    wr(ADDR_PORT_CFG, 32'h3C);
    wr(ADDR_SLOT_CAP, 32'h0);
    rc("slot_lock", ADDR_SLOT_CAP, 32'h3F);
    wr(ADDR_PORT_CFG, 32'h38);
    rc("slot_none", ADDR_SLOT_CAP, 32'h0);
    wr(12'h000, 32'hFFFFFFFF);
    chk("wr_unmapped", rsp, RESP_SLVERR);
    rc("rd_unmapped", 12'h004, 32'h0);
    chk("rresp_unmapped", rsp, RESP_SLVERR);
    give_verdict();
  end
endmodule : tb
